/* File: common/eru_pkg.sv */
// eru_pkg: constants, carriers and state types of the exception return unit
// assumes one core clock; software sees the unit over an AXI4-Lite slave
package eru_pkg;

  localparam logic [31:0] REG_OFS_CTRL   = 32'h00000000;
  localparam logic [31:0] REG_OFS_MSP    = 32'h00000004;
  localparam logic [31:0] REG_OFS_PSP    = 32'h00000008;
  localparam logic [31:0] REG_OFS_ACTLO  = 32'h0000000C;
  localparam logic [31:0] REG_OFS_ACTHI  = 32'h00000010;
  localparam logic [31:0] REG_OFS_STATUS = 32'h00000014;

  localparam int CTRL_SLEEP_BIT   = 0;
  localparam int CTRL_PRIORITY_MASK_BIT_BIT = 1;
  localparam int CTRL_NPRIV_BIT   = 2;

  localparam logic [31:0] RST_SP     = 32'h00000000;
  localparam logic [63:0] RST_ACTIVE = 64'h0000000000000000;

  localparam logic [3:0]  RET_TAG         = 4'hF;
  localparam logic [23:0] RET_MID_ONES    = 24'hFFFFFF;
  localparam logic [3:0]  RET_TO_HANDLER  = 4'h1;
  localparam logic [3:0]  RET_THREAD_MAIN = 4'h9;
  localparam logic [3:0]  RET_THREAD_PROC = 4'hD;

  localparam logic [31:0] FRAME_SIZE = 32'h00000020;
  localparam logic [2:0]  PSR_WORD   = 3'h7;
  localparam int PSR_ALIGN_BIT = 9;
  localparam int EXECUTION_STATE_BITS_T_BIT    = 24;
  localparam logic [5:0]  INTERRUPT_STATUS_FIELD_ZERO  = 6'h00;

  localparam logic [3:0]  REG_R12 = 4'hC;
  localparam logic [3:0]  REG_LR  = 4'hE;
  localparam logic [3:0]  REG_PC  = 4'hF;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_POP  = 3'b010,
    ST_FIN  = 3'b100
  } eru_fsm_type;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } eru_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } eru_axi_rsp_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        unpriv;
  } eru_mem_req_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic        fault;
  } eru_mem_rsp_type;

  typedef struct packed {
    logic        valid;
    logic [3:0]  idx;
    logic [31:0] data;
  } eru_reg_wr_type;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [3:0]  dest;
    logic [31:0] data;
  } eru_load_type;

  typedef struct packed {
    logic        valid;
    logic        restart;
    logic [3:0]  baseIdx;
    logic [31:0] base;
    logic        pcValid;
    logic [31:0] pc;
  } eru_restore_type;

  typedef struct packed {
    logic        valid;
    logic [5:0]  num;
  } eru_exc_type;

  typedef struct packed {
    logic        handlerMode;
    logic        stackSel;
    logic [5:0]  interrupt_status_field;
    logic [3:0]  application_flags;
    logic        epsrT;
    logic        lockup;
    logic        busy;
    logic [31:0] msp;
    logic [31:0] psp;
  } eru_stat_type;

endpackage

/* File: hdl/eru_core.sv */
// eru_core: exception return sequencer, replay helpers, late-arrival arbiter
// assumes a frame memory that answers one read at a time, and a core that
// applies register writes and restore requests on the cycle they are shown
`timescale 1ns/100ps
`default_nettype none
module eru_core
  import eru_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire eru_axi_req_type axiReq,
  output var  eru_axi_rsp_type axiRsp,
  input  wire logic            retValid,
  input  wire logic [31:0]     retValue,
  output var  eru_mem_req_type memReq,
  input  wire eru_mem_rsp_type memRsp,
  output var  eru_reg_wr_type  regWr,
  input  wire eru_load_type    ldRsp,
  output var  eru_reg_wr_type  ldWr,
  input  wire logic            multiStart,
  input  wire logic [3:0]      multiBaseIdx,
  input  wire logic [31:0]     multiBase,
  input  wire logic [31:0]     multiPc,
  input  wire logic            multiPcEarly,
  input  wire logic            multiDone,
  input  wire logic            multiAbandon,
  output var  eru_restore_type restore,
  input  wire logic            entryBusy,
  input  wire logic [7:0]      origPri,
  input  wire logic [5:0]      origNum,
  input  wire logic            lateValid,
  input  wire logic [7:0]      latePri,
  input  wire logic [5:0]      lateNum,
  output var  eru_exc_type     lateTake,
  output var  eru_exc_type     origKeep,
  output var  logic            hardFaultPend,
  output var  logic            eventSet,
  output var  logic            isbPulse,
  output var  logic            sleepReq,
  output var  eru_stat_type    stat
);

  typedef struct packed {
    eru_fsm_type     fsm;
    eru_axi_rsp_type axi;
    logic            awHave;
    logic [31:0]     awAddr;
    logic            wHave;
    logic [31:0]     wData;
    logic [3:0]      wStrb;
    logic [2:0]      ctrl;
    logic [63:0]     active;
    eru_stat_type    stat;
    logic [3:0]      code;
    logic [5:0]      retNum;
    logic [31:0]     frame;
    logic [2:0]      popIdx;
    eru_mem_req_type memReq;
    eru_reg_wr_type  regWr;
    eru_reg_wr_type  ldWr;
    logic            mTrack;
    logic            mEarly;
    logic [3:0]      mIdx;
    logic [31:0]     mBase;
    logic [31:0]     mPc;
    eru_restore_type restore;
    eru_exc_type     lateTake;
    eru_exc_type     origKeep;
    logic            hardFaultPend;
    logic            eventSet;
    logic            isbPulse;
    logic            sleepReq;
  } eru_core_state_type;

  eru_core_state_type state_ff;
  eru_core_state_type nxt_state;

  // register index 0..5, 7 means unmapped
  function automatic logic [2:0] regSel(input logic [31:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    unique case (addr)
      REG_OFS_CTRL:   sel = 3'h0;
      REG_OFS_MSP:    sel = 3'h1;
      REG_OFS_PSP:    sel = 3'h2;
      REG_OFS_ACTLO:  sel = 3'h3;
      REG_OFS_ACTHI:  sel = 3'h4;
      REG_OFS_STATUS: sel = 3'h5;
      default:        sel = 3'h7;
    endcase
    return sel;
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [6:0] countOnes(input logic [63:0] vec);
    logic [6:0] cnt;
    cnt = 7'h00;
    for (int i = 0; i < 64; i++) begin
      cnt = cnt + {6'h00, vec[i]};
    end
    return cnt;
  endfunction

  // frame word slot to core register number
  function automatic logic [3:0] frameReg(input logic [2:0] slot);
    logic [3:0] idx;
    idx = {1'b0, slot};
    if (slot == 3'h4) begin
      idx = REG_R12;
    end else if (slot == 3'h5) begin
      idx = REG_LR;
    end else if (slot == 3'h6) begin
      idx = REG_PC;
    end
    return idx;
  endfunction

  logic [6:0]  activeCnt;
  logic        isRetCode;
  logic        codeLegal;
  logic        useProc;
  logic        psrTake;
  logic        psrFault;
  logic        lateWins;
  logic [31:0] spNext;
  logic [5:0]  ipsrNext;

  assign activeCnt = countOnes(state_ff.active);
  assign isRetCode = retValid && state_ff.stat.handlerMode &&
                     (state_ff.fsm == ST_IDLE) && !state_ff.stat.lockup &&
                     (retValue[31:28] == RET_TAG);
  assign useProc   = (state_ff.code == RET_THREAD_PROC);
  assign psrTake   = (state_ff.fsm == ST_POP) && state_ff.memReq.valid &&
                     memRsp.valid && !memRsp.fault &&
                     (state_ff.popIdx == PSR_WORD);
  assign psrFault  = (state_ff.fsm == ST_POP) && state_ff.memReq.valid &&
                     memRsp.valid && memRsp.fault &&
                     (state_ff.popIdx == PSR_WORD);
  assign lateWins  = entryBusy && lateValid && (latePri < origPri);
  // frame size added first, realignment bit or-ed in afterwards
  assign spNext    = ((useProc ? state_ff.stat.psp : state_ff.stat.msp) +
                      FRAME_SIZE) |
                     {29'h00000000, memRsp.data[PSR_ALIGN_BIT], 2'b00};
  assign ipsrNext  = (!state_ff.stat.handlerMode && state_ff.ctrl[CTRL_NPRIV_BIT])
                     ? INTERRUPT_STATUS_FIELD_ZERO : memRsp.data[5:0];

  always_comb begin
    nxt_state = state_ff;
    codeLegal = 1'b0;
    nxt_state.regWr.valid    = 1'b0;
    nxt_state.ldWr.valid     = 1'b0;
    nxt_state.restore.valid  = 1'b0;
    nxt_state.lateTake.valid = 1'b0;
    nxt_state.origKeep.valid = 1'b0;
    nxt_state.hardFaultPend  = 1'b0;
    nxt_state.eventSet       = 1'b0;
    nxt_state.isbPulse       = 1'b0;
    nxt_state.sleepReq       = 1'b0;

    // register bus slave
    if (axiReq.awvalid && state_ff.axi.awready) begin
      nxt_state.awHave = 1'b1;
      nxt_state.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && state_ff.axi.wready) begin
      nxt_state.wHave = 1'b1;
      nxt_state.wData = axiReq.wdata;
      nxt_state.wStrb = axiReq.wstrb;
    end
    if (state_ff.axi.bvalid && axiReq.bready) begin
      nxt_state.axi.bvalid = 1'b0;
    end
    if (nxt_state.awHave && nxt_state.wHave && !nxt_state.axi.bvalid) begin
      nxt_state.awHave     = 1'b0;
      nxt_state.wHave      = 1'b0;
      nxt_state.axi.bvalid = 1'b1;
      nxt_state.axi.bresp  = RESP_OKAY;
      unique case (regSel(nxt_state.awAddr))
        3'h0: nxt_state.ctrl = 3'(mergeStrb({29'h00000000, state_ff.ctrl},
                                            nxt_state.wData,
                                            nxt_state.wStrb));
        3'h1: nxt_state.stat.msp = mergeStrb(state_ff.stat.msp,
                                             nxt_state.wData,
                                             nxt_state.wStrb);
        3'h2: nxt_state.stat.psp = mergeStrb(state_ff.stat.psp,
                                             nxt_state.wData,
                                             nxt_state.wStrb);
        3'h3: nxt_state.active[31:0] = mergeStrb(state_ff.active[31:0],
                                                 nxt_state.wData,
                                                 nxt_state.wStrb);
        3'h4: nxt_state.active[63:32] = mergeStrb(state_ff.active[63:32],
                                                  nxt_state.wData,
                                                  nxt_state.wStrb);
        // entry is not modelled: software enters handler mode by writing
        // the mode and number fields; the return sequencer overrides them
        3'h5: begin
          nxt_state.stat.handlerMode = nxt_state.wData[6];
          nxt_state.stat.interrupt_status_field        = nxt_state.wData[5:0];
        end
        default: nxt_state.axi.bresp = RESP_SLVERR;
      endcase
    end
    nxt_state.axi.awready = !nxt_state.awHave;
    nxt_state.axi.wready  = !nxt_state.wHave;

    if (state_ff.axi.rvalid && axiReq.rready) begin
      nxt_state.axi.rvalid = 1'b0;
    end
    if (axiReq.arvalid && state_ff.axi.arready) begin
      nxt_state.axi.rvalid = 1'b1;
      nxt_state.axi.rresp  = RESP_OKAY;
      nxt_state.axi.rdata  = 32'h00000000;
      unique case (regSel(axiReq.araddr))
        3'h0: nxt_state.axi.rdata = {29'h00000000, state_ff.ctrl};
        3'h1: nxt_state.axi.rdata = state_ff.stat.msp;
        3'h2: nxt_state.axi.rdata = state_ff.stat.psp;
        3'h3: nxt_state.axi.rdata = state_ff.active[31:0];
        3'h4: nxt_state.axi.rdata = state_ff.active[63:32];
        3'h5: nxt_state.axi.rdata = {state_ff.stat.application_flags, 3'h0,
                                     state_ff.stat.epsrT, 14'h0000,
                                     state_ff.stat.busy, state_ff.stat.lockup,
                                     state_ff.stat.stackSel,
                                     state_ff.stat.handlerMode,
                                     state_ff.stat.interrupt_status_field};
        default: nxt_state.axi.rresp = RESP_SLVERR;
      endcase
    end
    nxt_state.axi.arready = !nxt_state.axi.rvalid;

    // return sequencer; its updates land after any software write
    unique case (state_ff.fsm)
      ST_IDLE: begin
        if (isRetCode) begin
          codeLegal = (retValue[27:4] == RET_MID_ONES) &&
                      state_ff.active[state_ff.stat.interrupt_status_field] &&
                      (((retValue[3:0] == RET_TO_HANDLER) &&
                        (activeCnt > 7'h01)) ||
                       (((retValue[3:0] == RET_THREAD_MAIN) ||
                         (retValue[3:0] == RET_THREAD_PROC)) &&
                        (activeCnt == 7'h01)));
          if (!codeLegal) begin
            nxt_state.hardFaultPend = 1'b1;
          end else begin
            nxt_state.code   = retValue[3:0];
            nxt_state.retNum = state_ff.stat.interrupt_status_field;
            nxt_state.active[state_ff.stat.interrupt_status_field] = 1'b0;
            nxt_state.stat.handlerMode = (retValue[3:0] == RET_TO_HANDLER);
            nxt_state.stat.stackSel    = (retValue[3:0] == RET_THREAD_PROC);
            nxt_state.frame  = (retValue[3:0] == RET_THREAD_PROC) ?
                               state_ff.stat.psp : state_ff.stat.msp;
            nxt_state.popIdx = 3'h0;
            nxt_state.memReq.unpriv = (retValue[3:0] != RET_TO_HANDLER) &&
                                      state_ff.ctrl[CTRL_NPRIV_BIT];
            nxt_state.fsm = ST_POP;
          end
        end
      end
      ST_POP: begin
        if (!state_ff.memReq.valid) begin
          nxt_state.memReq.valid = 1'b1;
          nxt_state.memReq.addr  = state_ff.frame +
                                   {27'h0000000, state_ff.popIdx, 2'b00};
        end else if (memRsp.valid) begin
          nxt_state.memReq.valid = 1'b0;
          if (memRsp.fault) begin
            nxt_state.fsm = ST_IDLE;
            if (psrFault && !useProc) begin
              nxt_state.stat.lockup = 1'b1;
            end else begin
              nxt_state.hardFaultPend = 1'b1;
            end
          end else if (state_ff.popIdx != PSR_WORD) begin
            nxt_state.regWr.valid = 1'b1;
            nxt_state.regWr.idx   = frameReg(state_ff.popIdx);
            nxt_state.regWr.data  = memRsp.data;
            nxt_state.popIdx      = state_ff.popIdx + 3'h1;
          end else begin
            if (useProc) begin
              nxt_state.stat.psp = spNext;
            end else begin
              nxt_state.stat.msp = spNext;
            end
            nxt_state.stat.application_flags  = memRsp.data[31:28];
            nxt_state.stat.epsrT = memRsp.data[EXECUTION_STATE_BITS_T_BIT];
            nxt_state.stat.interrupt_status_field  = ipsrNext;
            // inconsistent frame pends a fault, then still finishes
            if ((state_ff.stat.handlerMode && (ipsrNext == INTERRUPT_STATUS_FIELD_ZERO)) ||
                (!state_ff.stat.handlerMode && (ipsrNext != INTERRUPT_STATUS_FIELD_ZERO))) begin
              nxt_state.hardFaultPend = 1'b1;
            end
            nxt_state.fsm = ST_FIN;
          end
        end
      end
      ST_FIN: begin
        nxt_state.eventSet = 1'b1;
        nxt_state.isbPulse = 1'b1;
        nxt_state.sleepReq = !state_ff.stat.handlerMode &&
                             state_ff.ctrl[CTRL_SLEEP_BIT];
        nxt_state.fsm = ST_IDLE;
      end
      default: nxt_state.fsm = ST_IDLE;
    endcase
    nxt_state.stat.busy = (nxt_state.fsm != ST_IDLE);

    // faulted single loads never reach the register file
    nxt_state.ldWr.valid = ldRsp.valid && !ldRsp.fault;
    nxt_state.ldWr.idx   = ldRsp.dest;
    nxt_state.ldWr.data  = ldRsp.data;

    if (multiStart) begin
      nxt_state.mTrack = 1'b1;
      nxt_state.mEarly = 1'b0;
      nxt_state.mIdx   = multiBaseIdx;
      nxt_state.mBase  = multiBase;
      nxt_state.mPc    = multiPc;
    end else if (state_ff.mTrack) begin
      if (multiAbandon) begin
        nxt_state.mTrack          = 1'b0;
        nxt_state.restore.valid   = 1'b1;
        nxt_state.restore.restart = 1'b1;
        nxt_state.restore.baseIdx = state_ff.mIdx;
        nxt_state.restore.base    = state_ff.mBase;
        nxt_state.restore.pcValid = state_ff.mEarly || multiPcEarly;
        nxt_state.restore.pc      = state_ff.mPc;
      end else if (multiDone) begin
        nxt_state.mTrack = 1'b0;
      end else if (multiPcEarly) begin
        nxt_state.mEarly = 1'b1;
      end
    end

    if (lateWins) begin
      nxt_state.lateTake.valid = 1'b1;
      nxt_state.lateTake.num   = lateNum;
      nxt_state.origKeep.valid = 1'b1;
      nxt_state.origKeep.num   = origNum;
    end

    if (!rst_b) begin
      nxt_state             = '0;
      nxt_state.fsm         = ST_IDLE;
      nxt_state.axi.awready = 1'b1;
      nxt_state.axi.wready  = 1'b1;
      nxt_state.axi.arready = 1'b1;
      nxt_state.active      = RST_ACTIVE;
      nxt_state.stat.msp    = RST_SP;
      nxt_state.stat.psp    = RST_SP;
    end
  end

  always_ff @(posedge clk) begin
    state_ff <= nxt_state;
  end

  assign axiRsp        = state_ff.axi;
  assign memReq        = state_ff.memReq;
  assign regWr         = state_ff.regWr;
  assign ldWr          = state_ff.ldWr;
  assign restore       = state_ff.restore;
  assign lateTake      = state_ff.lateTake;
  assign origKeep      = state_ff.origKeep;
  assign hardFaultPend = state_ff.hardFaultPend;
  assign eventSet      = state_ff.eventSet;
  assign isbPulse      = state_ff.isbPulse;
  assign sleepReq      = state_ff.sleepReq;
  assign stat          = state_ff.stat;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_main_lockup: assert property (psrFault && !useProc
      |=> stat.lockup)
    else $error("status word fault on main stack did not lock up");
  chk_proc_pend: assert property (psrFault && useProc |=> hardFaultPend)
    else $error("status word fault on process stack did not pend fault");
  chk_unpriv_reads: assert property (memReq.valid &&
      !stat.handlerMode && state_ff.ctrl[CTRL_NPRIV_BIT] |-> memReq.unpriv)
    else $error("thread frame read was not unprivileged");
  chk_interrupt_status_field_forced: assert property (psrTake && !stat.handlerMode &&
      state_ff.ctrl[CTRL_NPRIV_BIT] |=> stat.interrupt_status_field == INTERRUPT_STATUS_FIELD_ZERO)
    else $error("interrupt status not forced to zero");
  chk_bad_mid: assert property (isRetCode &&
      (retValue[27:4] != RET_MID_ONES) |=> hardFaultPend && !stat.busy)
    else $error("bad middle bits of return code not faulted");
  chk_deactivate: assert property (isRetCode && codeLegal
      |=> !state_ff.active[state_ff.retNum] && stat.busy)
    else $error("returning exception still active");
  chk_sp_advance: assert property (psrTake && !useProc
      |=> stat.msp == (($past(stat.msp) + FRAME_SIZE) |
                       {29'h00000000, $past(memRsp.data[PSR_ALIGN_BIT]),
                        2'b00}))
    else $error("main stack pointer not advanced correctly");
  chk_end_event: assert property (psrTake
      |=> ##1 eventSet && isbPulse)
    else $error("return did not end with event and barrier");
  chk_load_gate: assert property (ldRsp.valid && ldRsp.fault
      |=> !ldWr.valid)
    else $error("faulted load wrote its destination");
  chk_base_back: assert property (state_ff.mTrack && !multiStart &&
      multiAbandon |=> restore.valid && restore.base == $past(state_ff.mBase))
    else $error("abandoned multi access base not restored");
  chk_late_strict: assert property (lateTake.valid |->
      $past(entryBusy && lateValid && (latePri < origPri)) && origKeep.valid)
    else $error("late arrival without strictly higher priority");

endmodule
`default_nettype wire

/* File: tb/eru_frame_mem.sv */
// eru_frame_mem: stack frame memory seen by the return sequencer
// assumes one read held until answered, one word per request
`timescale 1ns/100ps
`default_nettype none
module eru_frame_mem
  import eru_pkg::*;
(
  input  wire logic            clk,
  input  wire logic [31:0]     faultAddr,
  input  wire eru_mem_req_type memReq,
  output var  eru_mem_rsp_type memRsp
);
  // answer on the cycle after a request is seen, then go quiet one cycle
  always_ff @(posedge clk) begin
    memRsp.valid <= memReq.valid && !memRsp.valid;
    // one chosen word answers with a fault
    memRsp.fault <= (memReq.addr == faultAddr);
    // idle data toggles so a stale word is never mistaken for a fresh one
    memRsp.data  <= memRsp.valid ? ~memRsp.data : ~memReq.addr;
  end
endmodule
`default_nettype wire

/* File: tb/exception_return_unit_tb_top.sv */
// exception_return_unit_tb_top: self-checking bench around eru_core
// assumes handler mode is entered by a status write standing in for entry
`timescale 1ns/100ps
`default_nettype none
module exception_return_unit_tb_top;
  import eru_pkg::*;
  logic            clk = '0, rst_b = '0, retValid = '0, lateValid = '0;
  logic            multiStart = '0, multiPcEarly = '0, multiDone = '0;
  logic            multiAbandon = '0, entryBusy = '0;
  logic [31:0]     retValue = '0, multiBase = '0, multiPc = '0;
  logic [3:0]      multiBaseIdx = '0;
  logic [7:0]      origPri = '0, latePri = '0;
  logic [5:0]      origNum = '0, lateNum = '0;
  logic [6:0]      seen = '0;
  logic [31:0]     faultAddr = '1;
  logic [3:0]      fin = '0;
  logic            hardFaultPend, eventSet, isbPulse, sleepReq;
  eru_axi_req_type axiReq = '0;
  eru_axi_rsp_type axiRsp;
  eru_mem_req_type memReq;
  eru_mem_rsp_type memRsp;
  eru_load_type    ldRsp = '0;
  eru_reg_wr_type  regWr, ldWr, lw, rw;
  eru_restore_type restore, rs;
  eru_exc_type     lateTake, origKeep, lt, ok;
  eru_stat_type    stat;
  int              numErrors = 0, samplesChecked = 0;

  eru_core      i_eru_core (.*);
  eru_frame_mem i_eru_frame_mem (.*);

  always #12.5 clk = ~clk;

  // pulses are caught at the falling edge, where outputs have settled
  always @(negedge clk) begin
    if (restore.valid) rs = restore;
    if (ldWr.valid) lw = ldWr;
    if (lateTake.valid) lt = lateTake;
    if (origKeep.valid) ok = origKeep;
    if (regWr.valid) rw = regWr;
    fin = fin | {eventSet, isbPulse, sleepReq, memReq.valid && memReq.unpriv};
    seen = seen | {hardFaultPend, stat.busy, memReq.valid, origKeep.valid,
                   lateTake.valid, restore.valid, ldWr.valid};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic reportAndStop;
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic axi(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, done;
    done = '0;
    @(posedge clk);
    axiReq.awaddr  <= a;
    axiReq.araddr  <= a;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hF;
    axiReq.awvalid <= wr;
    axiReq.wvalid  <= wr;
    axiReq.bready  <= wr;
    axiReq.arvalid <= !wr;
    axiReq.rready  <= !wr;
    while (!done) begin
      @(negedge clk);
      ta   = wr ? axiRsp.awready : axiRsp.arready;
      tw   = axiRsp.wready;
      done = wr ? axiRsp.bvalid : axiRsp.rvalid;
      q    = axiRsp.rdata;
      r    = wr ? axiRsp.bresp : axiRsp.rresp;
      @(posedge clk);
      if (ta) begin
        axiReq.awvalid <= '0;
        axiReq.arvalid <= '0;
      end
      if (tw) axiReq.wvalid <= '0;
      if (done) begin
        axiReq.bready <= '0;
        axiReq.rready <= '0;
      end
    end
  endtask

  task automatic testRegs;
    logic [31:0] q;
    logic [1:0]  r;
    axi(0, REG_OFS_STATUS, 32'h0, q, r);
    chk(q, 32'h0);
    axi(1, REG_OFS_PSP, 32'h0000_1FF8, q, r);
    axi(0, REG_OFS_PSP, 32'h0, q, r);
    chk(q, 32'h0000_1FF8);
    axi(1, REG_OFS_CTRL, 32'h7, q, r);
    axi(0, REG_OFS_CTRL, 32'h0, q, r);
    chk(q, 32'h7);
    axi(1, REG_OFS_STATUS, 32'hFFFF_FF80, q, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi(0, REG_OFS_STATUS, 32'h0, q, r);
    chk(q, 32'h0);
    axi(0, 32'h0000_0040, 32'h0, q, r);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask

  // thread mode: a return code is only an address, nothing must start
  task automatic testRetIgnored;
    @(posedge clk);
    retValid <= '1;
    retValue <= 32'hFFFF_FFF9;
    seen = '0;
    @(posedge clk);
    retValid <= '0;
    cyc(4);
    chk(32'(seen[6:4]), 32'h0);
  endtask

  task automatic testLoad;
    @(posedge clk);
    ldRsp <= {1'b1, 1'b0, 4'h3, 32'hCAFE_0001};
    @(posedge clk);
    ldRsp <= {1'b1, 1'b1, 4'h3, 32'h0BAD_0BAD};
    @(posedge clk);
    ldRsp <= '0;
    cyc(2);
    chk(lw.data, 32'hCAFE_0001);
  endtask

  task automatic testMulti;
    @(posedge clk);
    multiStart   <= '1;
    multiBaseIdx <= 4'h2;
    multiBase    <= 32'h0000_2000;
    multiPc      <= 32'h0000_0100;
    @(posedge clk);
    multiStart   <= '0;
    multiPcEarly <= '1;
    @(posedge clk);
    multiPcEarly <= '0;
    multiAbandon <= '1;
    @(posedge clk);
    multiAbandon <= '0;
    cyc(2);
    chk(rs.base, 32'h0000_2000);
    chk({rs.pc[30:0], rs.pcValid}, 32'h0000_0201);
    chk(32'({rs.restart, rs.baseIdx}), 32'h12);
  endtask

  task automatic testLate(input logic [7:0] p, input logic [6:0] exp);
    @(posedge clk);
    entryBusy <= '1;
    origPri   <= 8'h40;
    origNum   <= 6'h10;
    latePri   <= p;
    lateNum   <= 6'h11;
    lateValid <= '1;
    seen = '0;
    @(posedge clk);
    lateValid <= '0;
    entryBusy <= '0;
    cyc(2);
    chk(32'(seen[3:2]), 32'(exp[1:0]));
  endtask

  // number 3 active alone, handler mode set by a status write
  task automatic retSeq(input logic [31:0] code);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1, REG_OFS_ACTLO, 32'h8, q, r);
    axi(1, REG_OFS_STATUS, 32'h43, q, r);
    seen = '0;
    fin  = '0;
    @(posedge clk);
    retValid <= '1;
    retValue <= code;
    @(posedge clk);
    retValid <= '0;
    cyc(40);
  endtask

  // frame memory answers each word with the inverse of its address
  task automatic testReturn;
    logic [31:0] q;
    logic [1:0]  r;
    axi(1, REG_OFS_MSP, 32'h0000_1000, q, r);
    retSeq(32'hFFF0_FFF9);
    chk(32'(seen[6:5]), 32'h2);
    retSeq(32'hFFFF_FFF1);
    chk(32'(seen[6:5]), 32'h2);
    retSeq(32'hFFFF_FFF9);
    chk(32'({seen[6], fin}), 32'hF);
    chk(rw.data, 32'hFFFF_EFE7);
    chk(32'(rw.idx), 32'(REG_PC));
    axi(0, REG_OFS_MSP, 32'h0, q, r);
    chk(q, 32'h0000_1024);
    axi(0, REG_OFS_STATUS, 32'h0, q, r);
    chk(q, 32'hF100_0000);
    axi(0, REG_OFS_ACTLO, 32'h0, q, r);
    chk(q, 32'h0);
    faultAddr <= 32'h0000_2014;
    retSeq(32'hFFFF_FFFD);
    chk(32'({seen[6], fin[3]}), 32'h2);
    faultAddr <= 32'h0000_1040;
    retSeq(32'hFFFF_FFF9);
    axi(0, REG_OFS_STATUS, 32'h0, q, r);
    chk(32'(q[8]), 32'h1);
    rst_b <= '0;
    cyc(2);
    rst_b <= '1;
    axi(0, REG_OFS_STATUS, 32'h0, q, r);
    chk(q, 32'h0);
  endtask

  initial begin
    cyc(16);
    rst_b <= '1;
    testRegs;
    testRetIgnored;
    testLoad;
    testMulti;
    testLate(8'h20, 7'h3);
    chk(32'({lt.num, ok.num}), 32'h0450);
    testLate(8'h40, 7'h0);
    testReturn;
    reportAndStop;
  end

  initial begin
    cyc(3000);
    numErrors++;
    reportAndStop;
  end
endmodule
`default_nettype wire
